// File: inc/acqif_pkg.sv
// Package for the eight channel converter bus interface.
// Assumes a single 250 MHz system clock shared by both ends.
package acqif_pkg;
  localparam int CLK_PERIOD_NS = 4;
  // Conversion time in nanoseconds and derived cycle counts.
  localparam int CONV_TIME_NS = 25000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Converter clock limit of 1.4 MHz, expressed as a least period in ns.
  localparam int CONV_CLK_MIN_PERIOD_NS = 715;
  // The divider rounds up to whole system clocks, keeping the modelled converter clock at or below the limit.
  localparam int CONV_CLK_DIV = (CONV_CLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Converter clock cycles of the sampling phase.
  localparam int SAMPLE_CONV_CLKS = 9;
  localparam int SAMPLE_CYCLES = SAMPLE_CONV_CLKS * CONV_CLK_DIV;
  localparam int DATA_W = 8;
  localparam int CHAN_W = 3;
  localparam logic [15:0] MEM_BASE = 16'h8000;
  localparam logic [7:0] PORT_DIR_CFG = 8'h7F;
  localparam int PORT_CHAN_LSB = 4;
  localparam int ADDR_DECODE_BIT = 15;
  localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
  localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
  typedef enum logic [1:0] {
    ACQIF_IDLE = 2'b00,
    ACQIF_SAMPLE = 2'b01,
    ACQIF_CONVERT = 2'b11,
    ACQIF_DONE = 2'b10
  } acqif_state_t;
endpackage : acqif_pkg

// File: inc/acqif_if.sv
// Interface joining the converter device end and the controller end.
// Assumes both ends run on one clock; the data bus is carried as separate data and enable signals.
`timescale 1ns/100ps
`default_nettype none
interface acqif_if;
  logic [2:0] chan_addr;
  logic channel_latch_load;
  logic conversion_kick_pulse;
  logic output_drive_enable;
  logic end_of_conv;
  logic [7:0] data_out;
  logic [7:0] data_oe;
  modport device (
    input chan_addr,
    input channel_latch_load,
    input conversion_kick_pulse,
    input output_drive_enable,
    output end_of_conv,
    output data_out,
    output data_oe
  );
  modport ctrl (
    output chan_addr,
    output channel_latch_load,
    output conversion_kick_pulse,
    output output_drive_enable,
    input end_of_conv,
    input data_out,
    input data_oe
  );
endinterface : acqif_if
`default_nettype wire

// File: hw/acqif_device.sv
// Device end: channel latch, timed conversion, result latch, gated data drive.
// Assumes a synchronous one-cycle start strobe from the controller end.
// Behaviour
// - Three address bits select one of eight inputs.
// - Eight-bit successive approximation result held in latch.
// - Controller holds channel for nine converter clocks.
// - End-of-conversion rises when new data present.
// - Converter clock at most 1.4 MHz.
// - Converter clock duty 20 to 80 percent.
// - Conversion takes about 25 microseconds.
// - Data driven only while output enable asserted.
// - Address latched on load; result latched.
// - Free-running: start tied to end-of-conversion.
// - Free-running controller reads only while flag high; the code holds output_drive_enable high throughout free-running mode.
// - Port bits six to zero out, seven in.
// - Channel in upper nibble, or base plus n.
// - Memory-mapped write to channel address starts.
// - Strobes decoded from address bit fifteen.
// - Rising end-of-conversion interrupts, then bus read.
`timescale 1ns/100ps
`default_nettype none
module acqif_device #(
  parameter int CONV_CYCLES = acqif_pkg::CONV_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0][7:0] analog_in,
  acqif_if.device bus
);
  acqif_pkg::acqif_state_t state_reg;
  logic [2:0] chan_reg;
  logic [7:0] sample_reg;
  logic [7:0] sar_reg;
  logic [7:0] bit_reg;
  logic [7:0] result_reg;
  logic eoc_reg;
  logic [31:0] cnt_reg;
  logic [7:0] trial;
  // Each SAR step gets an equal share of the conversion time left after the sampling phase.
  localparam int STEP_CYCLES = (CONV_CYCLES - acqif_pkg::SAMPLE_CYCLES) / 8;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_reg <= acqif_pkg::CHAN_RST;
    end else if (bus.channel_latch_load) begin
      chan_reg <= bus.chan_addr;
    end
  end

  assign trial = sar_reg | bit_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= acqif_pkg::ACQIF_IDLE;
      cnt_reg <= 32'h0;
      sample_reg <= 8'h00;
      sar_reg <= 8'h00;
      bit_reg <= 8'h80;
    end else if (bus.conversion_kick_pulse) begin
      state_reg <= acqif_pkg::ACQIF_SAMPLE;
      cnt_reg <= 32'h0;
      sar_reg <= 8'h00;
      bit_reg <= 8'h80;
    end else begin
      case (state_reg)
        acqif_pkg::ACQIF_SAMPLE: begin
          // The input is tracked during the whole sampling phase.
          sample_reg <= analog_in[chan_reg];
          if (cnt_reg == 32'(acqif_pkg::SAMPLE_CYCLES - 1)) begin
            state_reg <= acqif_pkg::ACQIF_CONVERT;
            cnt_reg <= 32'h0;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        acqif_pkg::ACQIF_CONVERT: begin
          if (cnt_reg == 32'(STEP_CYCLES - 1)) begin
            cnt_reg <= 32'h0;
            if (trial <= sample_reg) begin
              sar_reg <= trial;
            end
            bit_reg <= bit_reg >> 1;
            if (bit_reg == 8'h01) begin
              state_reg <= acqif_pkg::ACQIF_DONE;
            end
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        acqif_pkg::ACQIF_DONE: begin
          state_reg <= acqif_pkg::ACQIF_IDLE;
        end
        default: begin
          state_reg <= acqif_pkg::ACQIF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_reg <= acqif_pkg::RESULT_RST;
      eoc_reg <= 1'b0;
    end else if (bus.conversion_kick_pulse) begin
      eoc_reg <= 1'b0;
    end else if (state_reg == acqif_pkg::ACQIF_DONE) begin
      result_reg <= sar_reg;
      eoc_reg <= 1'b1;
    end
  end

  assign bus.end_of_conv = eoc_reg;
  assign bus.data_out = result_reg;
  assign bus.data_oe = {8{bus.output_drive_enable}};
endmodule : acqif_device
`default_nettype wire

// File: hw/acqif_ctrl.sv
// Controller end: free-running port mode or memory-mapped bus mode.
// Assumes a synchronous user side issuing bus cycles one at a time.
`timescale 1ns/100ps
`default_nettype none
module acqif_ctrl (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic free_run,
  input wire logic [2:0] port_chan,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic conv_irq,
  acqif_if.ctrl bus
);
  logic eoc_d_reg;
  logic [7:0] port_out;
  logic sel;

  // Channel number sits in the upper nibble of the port byte.
  assign port_out = {1'b0, port_chan, 4'h0};
  // Only bit 15 is decoded, so the device aliases across the upper half.
  assign sel = mem_addr[acqif_pkg::ADDR_DECODE_BIT];

  always_comb begin
    if (free_run) begin
      bus.chan_addr = port_out[6:4];
      bus.channel_latch_load = 1'b1;
      bus.conversion_kick_pulse = bus.end_of_conv & ~eoc_d_reg;
      bus.output_drive_enable = 1'b1;
    end else begin
      bus.chan_addr = mem_addr[2:0];
      bus.channel_latch_load = sel & mem_wr;
      bus.conversion_kick_pulse = sel & mem_wr;
      bus.output_drive_enable = sel & mem_rd;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eoc_d_reg <= 1'b0;
      conv_irq <= 1'b0;
    end else begin
      eoc_d_reg <= bus.end_of_conv;
      conv_irq <= bus.end_of_conv & ~eoc_d_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (free_run && bus.end_of_conv && !eoc_d_reg) begin
        rd_data <= bus.data_out;
        rd_valid <= 1'b1;
      end else if (!free_run && sel && mem_rd) begin
        rd_data <= bus.data_out;
        rd_valid <= 1'b1;
      end
    end
  end
endmodule : acqif_ctrl
`default_nettype wire

// File: dv/acqif_chk.sv
// Checker on the link between the converter end and the controller end.
// Assumes one clock and a conversion count of 1700 cycles.
`timescale 1ns/100ps
`default_nettype none
module acqif_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic conversion_kick_pulse,
  input wire logic output_drive_enable,
  input wire logic end_of_conv,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe
);
  localparam int T_MAX = 1800;
  int cnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Cycles since the last kick; sampling alone takes 1611 of them.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 0;
    end else if (conversion_kick_pulse) begin
      cnt_reg <= 0;
    end else begin
      cnt_reg <= cnt_reg + 1;
    end
  end
  AST_OE: assert property (data_oe == {8{output_drive_enable}})
    else $error("data drive differs from enable");
  AST_DROP: assert property (conversion_kick_pulse |=> !end_of_conv)
    else $error("done flag not dropped by kick");
  AST_FALL: assert property ($fell(end_of_conv) |-> $past(conversion_kick_pulse))
    else $error("done flag fell without kick");
  AST_MIN: assert property ($rose(end_of_conv) |-> cnt_reg >= 1611)
    else $error("conversion finished too early");
  // A new kick restarts the conversion, so it also ends the wait for the old one.
  AST_BOUND: assert property (conversion_kick_pulse |-> ##[1:T_MAX] (end_of_conv || conversion_kick_pulse))
    else $error("conversion never finished");
  AST_STAY: assert property (end_of_conv && !conversion_kick_pulse |=> end_of_conv)
    else $error("done flag lost");
  AST_HOLD: assert property (!$stable(data_out) |-> $rose(end_of_conv))
    else $error("result changed outside completion");
  AST_PULSE: assert property (conversion_kick_pulse |=> !conversion_kick_pulse)
    else $error("kick longer than one cycle");
  COV_KICK: cover property (conversion_kick_pulse);
  COV_DONE: cover property ($rose(end_of_conv));
  COV_DRIVE: cover property (output_drive_enable);
endmodule : acqif_chk
`default_nettype wire

// File: dv/tb.sv
// Testbench joining both ends, driving memory mode then free-running mode.
// Assumes the design's conversion count is shortened to 1700 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic free_run = 1'b0;
  logic [2:0] port_chan = 3'h3;
  logic mem_wr = 1'b0;
  logic mem_rd = 1'b0;
  logic [15:0] mem_addr = 16'h0000;
  logic [7:0][7:0] analog_in;
  logic [7:0] rd_data;
  logic rd_valid;
  logic conv_irq;
  int errors = 0;
  int samples_checked = 0;
  int i;
  acqif_if bus();
  always #2 clk = ~clk;
  acqif_device #(.CONV_CYCLES(1700)) u_acqif_device (.clk(clk), .arst_n(arst_n),
    .analog_in(analog_in), .bus(bus));
  acqif_ctrl u_acqif_ctrl (.clk(clk), .arst_n(arst_n), .free_run(free_run),
    .port_chan(port_chan), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .conv_irq(conv_irq), .bus(bus));
  acqif_chk u_acqif_chk (.clk(clk), .arst_n(arst_n),
    .conversion_kick_pulse(bus.conversion_kick_pulse),
    .output_drive_enable(bus.output_drive_enable), .end_of_conv(bus.end_of_conv),
    .data_out(bus.data_out), .data_oe(bus.data_oe));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic mem_op(input logic rd, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    mem_wr <= ~rd;
    mem_rd <= rd;
    mem_addr <= a;
    #1;
    chk8(bus.data_oe, {8{rd}});
    @(posedge clk);
    mem_wr <= 1'b0;
    mem_rd <= 1'b0;
    #1;
    if (rd) chk8(rd_data, exp);
  endtask : mem_op
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (s !== 1'b1 && n < 2000);
    chk8({7'h00, s}, 8'h01);
  endtask : wait_hi
  task automatic test_done;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    for (i = 0; i < 8; i++) analog_in[i] = 8'(i) * 8'h25 + 8'h05;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 8; i++) begin
      mem_op(1'b0, 16'h8000 + 16'(i), 8'h00);
      wait_hi(conv_irq);
      mem_op(1'b1, 16'h8000 + 16'(i), analog_in[i]);
    end
    mem_op(1'b0, 16'h0003, 8'h00);
    repeat (20) @(posedge clk);
    #1;
    chk8({7'h00, bus.end_of_conv}, 8'h01);
    mem_op(1'b0, 16'h8002, 8'h00);
    repeat (200) @(posedge clk);
    mem_op(1'b0, 16'h8005, 8'h00);
    // Free-running mode relatches the channel, so switch only once sampling is over.
    repeat (acqif_pkg::SAMPLE_CYCLES + 30) @(posedge clk);
    free_run <= 1'b1;
    wait_hi(rd_valid);
    chk8(rd_data, analog_in[5]);
    wait_hi(rd_valid);
    chk8(rd_data, analog_in[3]);
    test_done();
  end
  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule : tb
`default_nettype wire
